// file: design/mab_consts.svh
`ifndef MAB_CONSTS_SVH
`define MAB_CONSTS_SVH
// status flag bit positions
`define MAB_FLAG_C 0
`define MAB_FLAG_Z 1
`define MAB_FLAG_N 2
`define MAB_FLAG_V 3
`define MAB_FLAG_S 4
`define MAB_FLAG_H 5
// flag groups each instruction class may touch
`define MAB_MASK_ARITH 8'h2f
`define MAB_MASK_WORD 8'h1f
`define MAB_MASK_LOGIC 8'h0e
`define MAB_MASK_INV 8'h0f
`define MAB_MASK_NONE 8'h00
`define MAB_STATUS_RST 8'h00
`define MAB_ONES 8'hff
// cycle counts per instruction
`define MAB_CYC_ONE 3'h1
`define MAB_CYC_WORD 3'h2
`define MAB_CYC_RELATIVE_JUMP 3'h2
`define MAB_CYC_INDIRECT_JUMP 3'h2
`define MAB_CYC_JMP 3'h3
`define MAB_CYC_RELATIVE_CALL 3'h3
`define MAB_CYC_INDIRECT_CALL 3'h3
`define MAB_CYC_CALL 3'h4
`define MAB_CYC_SKIP1 3'h2
`define MAB_CYC_SKIP2 3'h3
`define MAB_CYC_BRANCH 3'h2
// program counter steps
`define MAB_PC_STEP 16'h0001
`define MAB_PC_SKIP1 16'h0002
`define MAB_PC_SKIP2 16'h0003
`define MAB_PC_LONG 16'h0002
`endif

// file: design/mab_pkg.sv
package mab_pkg;
   typedef enum logic [5:0] {
      op_add, op_add_carry, op_word_add_immediate, op_subtract,
      op_subtract_immediate, op_subtract_with_borrow,
      op_subtract_borrow_immediate, op_word_subtract_immediate,
      op_and, op_and_immediate, op_or, op_or_immediate, op_exclusive_or,
      op_bitwise_invert, op_arithmetic_invert, op_set_bits_mask,
      op_clear_bits_mask, op_increment, op_minus_one, op_self_and_test,
      op_register_zero, op_register_fill_ones, op_relative_jump,
      op_indirect_jump, op_absolute_jump, op_relative_call,
      op_indirect_call, op_direct_call, op_compare_skip_equal,
      op_compare_only, op_compare_with_borrow, op_compare_immediate,
      op_skip_reg_bit_clear, op_skip_reg_bit_set, op_skip_io_bit_clear,
      op_skip_io_bit_set, op_branch_flag_set
   } mab_op_t;
   typedef enum logic [1:0] {st_idle = 2'b01, st_busy = 2'b10} mab_state_t;
   typedef enum logic [2:0] {
      alu_add, alu_sub, alu_and, alu_or, alu_xor, alu_com
   } mab_alu_t;
endpackage

// file: design/mab_alu.sv
`timescale 1ns/100ps
`default_nettype none
`include "mab_consts.svh"
module mab_alu (
   input wire mab_pkg::mab_alu_t op,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic ci,
   output logic [7:0] res,
   output logic [7:0] flags
);
   import mab_pkg::*;
   logic h;
   logic v;
   logic c;
   // carry-chain equations give half-carry without a separate nibble adder
   always_comb begin
      res = 8'h00;
      h = 1'b0;
      v = 1'b0;
      c = 1'b0;
      case (op)
         alu_add: begin
            res = a + b + {7'h00, ci};
            h = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
            v = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
            c = (a[7] & b[7]) | (b[7] & ~res[7]) | (~res[7] & a[7]);
         end
         alu_sub: begin
            res = a - b - {7'h00, ci};
            h = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
            v = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
            c = (~a[7] & b[7]) | (b[7] & res[7]) | (res[7] & ~a[7]);
         end
         alu_and: res = a & b;
         alu_or: res = a | b;
         alu_xor: res = a ^ b;
         alu_com: begin
            res = `MAB_ONES - a;
            c = 1'b1;
         end
         default: res = 8'h00;
      endcase
      flags = 8'h00;
      flags[`MAB_FLAG_H] = h;
      flags[`MAB_FLAG_V] = v;
      flags[`MAB_FLAG_N] = res[7];
      flags[`MAB_FLAG_Z] = (res == 8'h00);
      flags[`MAB_FLAG_C] = c;
   end
endmodule
`default_nettype wire

// file: design/mab_exec.sv
// Function
// - add and add-with-carry sum operands, set Z C N V H, one cycle.
// - word add immediate adds constant to pair, Z C N V S, two cycles.
// - subtract register or constant, write result, Z C N V H, 1 cycle.
// - borrow forms also subtract carry, same flags, 1 cycle.
// - word subtract immediate on pair, Z C N V S, two cycles.
// - and, or, xor write result, touch only Z N V, one cycle.
// - invert gives all-ones minus value, sets Z C N V, one cycle.
// - negate gives zero minus value, sets Z C N V H, one cycle.
// - set-bits ors mask, clear-bits ands inverted mask, Z N V.
// - increment and decrement touch Z N V only, carry kept, 1 cycle.
// - test ands self, clear xors self; fill-ones leaves flags alone.
// - relative and indirect jump two cycles, absolute jump three.
// - relative and indirect call three cycles, direct four, no flags.
// - compare-skip-equal skips by 2 or 3 words, 1/2/3 cycles.
// - compares compute difference, write nothing, Z N V C H, 1 cycle.
// - skip on register bit clear or set, 1/2/3 cycles.
// - skip on I/O bit clear or set, flags untouched.
// - branch on flag set adds offset plus one when flag is one.
`timescale 1ns/100ps
`default_nettype none
`include "mab_consts.svh"
module mab_exec (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic START,
   input wire mab_pkg::mab_op_t OPCODE,
   input wire logic [7:0] DEST,
   input wire logic [7:0] SRC,
   input wire logic [7:0] IMM,
   input wire logic [15:0] WORD_IN,
   input wire logic [5:0] WORD_K,
   input wire logic [15:0] PC_IN,
   input wire logic [15:0] OFFSET,
   input wire logic [15:0] TARGET,
   input wire logic [15:0] Z_PTR,
   input wire logic NEXT_TWO_WORD,
   input wire logic [7:0] IO_REG,
   input wire logic [2:0] BIT_SEL,
   input wire logic [2:0] FLAG_SEL,
   output logic [7:0] RESULT,
   output logic WRITE_DEST,
   output logic [15:0] RESULT_WORD,
   output logic WRITE_WORD,
   output logic [7:0] STATUS,
   output logic [15:0] PC_OUT,
   output logic [15:0] RETURN_ADDR,
   output logic PUSH_RETURN,
   output logic DONE,
   output logic BUSY
);
   import mab_pkg::*;
   mab_alu_t a_op;
   logic [7:0] a_a;
   logic [7:0] a_b;
   logic a_ci;
   logic [7:0] a_res;
   logic [7:0] a_fl;
   logic [7:0] d_mask;
   logic [7:0] d_fl;
   logic [7:0] d_stat;
   logic [7:0] d_res;
   logic [15:0] d_word;
   logic [15:0] d_pc;
   logic [15:0] d_ret;
   logic [2:0] d_cyc;
   logic d_wr;
   logic d_wrw;
   logic d_push;
   logic skip;
   logic [15:0] pc_inc;
   logic [15:0] pc_rel;
   logic [15:0] w_sum;
   mab_state_t state;
   mab_state_t next_state;
   logic [2:0] rem;
   logic [2:0] next_rem;
   logic [7:0] pstat;
   logic [7:0] next_pstat;
   logic [2:0] pstr;
   logic [2:0] next_pstr;
   logic [7:0] next_result;
   logic [15:0] next_result_word;
   logic [7:0] next_status;
   logic [15:0] next_pc_out;
   logic [15:0] next_return_addr;
   logic next_write_dest;
   logic next_write_word;
   logic next_push_return;
   logic next_done;

   mab_alu u_alu (
      .op(a_op),
      .a(a_a),
      .b(a_b),
      .ci(a_ci),
      .res(a_res),
      .flags(a_fl)
   );

   assign pc_inc = PC_IN + `MAB_PC_STEP;
   assign pc_rel = PC_IN + OFFSET + `MAB_PC_STEP;
   // 16-bit pair arithmetic stays here; the byte alu has no word path
   assign w_sum = (OPCODE == op_word_add_immediate) ?
                  WORD_IN + {10'h000, WORD_K} : WORD_IN - {10'h000, WORD_K};

   // decode: operands, flag group, target, cycle count
   always_comb begin
      a_op = alu_add;
      a_a = DEST;
      a_b = SRC;
      a_ci = 1'b0;
      d_mask = `MAB_MASK_NONE;
      d_wr = 1'b0;
      d_wrw = 1'b0;
      d_push = 1'b0;
      d_pc = pc_inc;
      d_ret = pc_inc;
      d_cyc = `MAB_CYC_ONE;
      d_fl = a_fl;
      skip = 1'b0;
      case (OPCODE)
         op_add, op_add_carry: begin
            a_ci = (OPCODE == op_add_carry) & STATUS[`MAB_FLAG_C];
            d_mask = `MAB_MASK_ARITH;
            d_wr = 1'b1;
         end
         op_subtract, op_subtract_immediate: begin
            a_op = alu_sub;
            a_b = (OPCODE == op_subtract) ? SRC : IMM;
            d_mask = `MAB_MASK_ARITH;
            d_wr = 1'b1;
         end
         op_subtract_with_borrow, op_subtract_borrow_immediate: begin
            a_op = alu_sub;
            a_b = (OPCODE == op_subtract_with_borrow) ? SRC : IMM;
            a_ci = STATUS[`MAB_FLAG_C];
            d_mask = `MAB_MASK_ARITH;
            d_wr = 1'b1;
         end
         op_word_add_immediate, op_word_subtract_immediate: begin
            d_fl = 8'h00;
            d_fl[`MAB_FLAG_N] = w_sum[15];
            d_fl[`MAB_FLAG_Z] = (w_sum == 16'h0000);
            if (OPCODE == op_word_add_immediate) begin
               d_fl[`MAB_FLAG_V] = ~WORD_IN[15] & w_sum[15];
               d_fl[`MAB_FLAG_C] = WORD_IN[15] & ~w_sum[15];
            end else begin
               d_fl[`MAB_FLAG_V] = WORD_IN[15] & ~w_sum[15];
               d_fl[`MAB_FLAG_C] = ~WORD_IN[15] & w_sum[15];
            end
            d_fl[`MAB_FLAG_S] = d_fl[`MAB_FLAG_N] ^ d_fl[`MAB_FLAG_V];
            d_mask = `MAB_MASK_WORD;
            d_wrw = 1'b1;
            d_cyc = `MAB_CYC_WORD;
         end
         op_and, op_and_immediate, op_self_and_test, op_clear_bits_mask: begin
            a_op = alu_and;
            a_b = (OPCODE == op_and) ? SRC : IMM;
            if (OPCODE == op_self_and_test) a_b = DEST;
            if (OPCODE == op_clear_bits_mask) a_b = `MAB_ONES - IMM;
            d_mask = `MAB_MASK_LOGIC;
            d_wr = 1'b1;
         end
         op_or, op_or_immediate, op_set_bits_mask: begin
            a_op = alu_or;
            a_b = (OPCODE == op_or) ? SRC : IMM;
            d_mask = `MAB_MASK_LOGIC;
            d_wr = 1'b1;
         end
         op_exclusive_or, op_register_zero: begin
            a_op = alu_xor;
            if (OPCODE == op_register_zero) a_b = DEST;
            d_mask = `MAB_MASK_LOGIC;
            d_wr = 1'b1;
         end
         op_bitwise_invert: begin
            a_op = alu_com;
            d_mask = `MAB_MASK_INV;
            d_wr = 1'b1;
         end
         op_arithmetic_invert: begin
            a_op = alu_sub;
            a_a = 8'h00;
            a_b = DEST;
            d_mask = `MAB_MASK_ARITH;
            d_wr = 1'b1;
         end
         op_increment, op_minus_one: begin
            a_op = (OPCODE == op_increment) ? alu_add : alu_sub;
            a_b = 8'h01;
            d_mask = `MAB_MASK_LOGIC;
            d_wr = 1'b1;
         end
         op_register_fill_ones: begin
            a_op = alu_or;
            a_b = `MAB_ONES;
            d_wr = 1'b1;
         end
         op_compare_only, op_compare_with_borrow, op_compare_immediate: begin
            a_op = alu_sub;
            a_b = (OPCODE == op_compare_immediate) ? IMM : SRC;
            a_ci = (OPCODE == op_compare_with_borrow) & STATUS[`MAB_FLAG_C];
            d_mask = `MAB_MASK_ARITH;
         end
         op_relative_jump: begin
            d_pc = pc_rel;
            d_cyc = `MAB_CYC_RELATIVE_JUMP;
         end
         op_indirect_jump: begin
            d_pc = Z_PTR;
            d_cyc = `MAB_CYC_INDIRECT_JUMP;
         end
         op_absolute_jump: begin
            d_pc = TARGET;
            d_cyc = `MAB_CYC_JMP;
         end
         op_relative_call, op_indirect_call: begin
            d_pc = (OPCODE == op_relative_call) ? pc_rel : Z_PTR;
            d_push = 1'b1;
            d_cyc = `MAB_CYC_RELATIVE_CALL;
         end
         op_direct_call: begin
            d_pc = TARGET;
            d_ret = PC_IN + `MAB_PC_LONG;
            d_push = 1'b1;
            d_cyc = `MAB_CYC_CALL;
         end
         op_compare_skip_equal: skip = (DEST == SRC);
         op_skip_reg_bit_clear: skip = ~SRC[BIT_SEL];
         op_skip_reg_bit_set: skip = SRC[BIT_SEL];
         op_skip_io_bit_clear: skip = ~IO_REG[BIT_SEL];
         op_skip_io_bit_set: skip = IO_REG[BIT_SEL];
         op_branch_flag_set: begin
            if (STATUS[FLAG_SEL]) begin
               d_pc = pc_rel;
               d_cyc = `MAB_CYC_BRANCH;
            end
         end
         default: d_cyc = `MAB_CYC_ONE;
      endcase
      // skipped instruction length sets both step and cycle count
      if (skip) begin
         d_pc = PC_IN + (NEXT_TWO_WORD ? `MAB_PC_SKIP2 : `MAB_PC_SKIP1);
         d_cyc = NEXT_TWO_WORD ? `MAB_CYC_SKIP2 : `MAB_CYC_SKIP1;
      end
      d_res = a_res;
      d_word = w_sum;
      d_stat = (STATUS & ~d_mask) | (d_fl & d_mask);
   end

   // sequencing: data outputs load at start, flags and strobes at the end
   always_comb begin
      next_state = state;
      next_rem = rem;
      next_pstat = pstat;
      next_pstr = pstr;
      next_result = RESULT;
      next_result_word = RESULT_WORD;
      next_status = STATUS;
      next_pc_out = PC_OUT;
      next_return_addr = RETURN_ADDR;
      next_write_dest = 1'b0;
      next_write_word = 1'b0;
      next_push_return = 1'b0;
      next_done = 1'b0;
      case (state)
         st_idle: begin
            if (START) begin
               next_result = d_res;
               next_result_word = d_word;
               next_pc_out = d_pc;
               next_return_addr = d_ret;
               if (d_cyc == `MAB_CYC_ONE) begin
                  next_status = d_stat;
                  next_write_dest = d_wr;
                  next_write_word = d_wrw;
                  next_push_return = d_push;
                  next_done = 1'b1;
               end else begin
                  next_state = st_busy;
                  next_rem = d_cyc - 3'h1;
                  next_pstat = d_stat;
                  next_pstr = {d_wr, d_wrw, d_push};
               end
            end
         end
         st_busy: begin
            // start requests are ignored here; the core stalls on busy
            next_rem = rem - 3'h1;
            if (rem == 3'h1) begin
               next_state = st_idle;
               next_status = pstat;
               next_write_dest = pstr[2];
               next_write_word = pstr[1];
               next_push_return = pstr[0];
               next_done = 1'b1;
            end
         end
         default: next_state = st_idle;
      endcase
   end

   // registers only
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state <= st_idle;
         rem <= 3'h0;
         pstat <= 8'h00;
         pstr <= 3'h0;
         RESULT <= 8'h00;
         RESULT_WORD <= 16'h0000;
         STATUS <= `MAB_STATUS_RST;
         PC_OUT <= 16'h0000;
         RETURN_ADDR <= 16'h0000;
         WRITE_DEST <= 1'b0;
         WRITE_WORD <= 1'b0;
         PUSH_RETURN <= 1'b0;
         DONE <= 1'b0;
         BUSY <= 1'b0;
      end else begin
         state <= next_state;
         rem <= next_rem;
         pstat <= next_pstat;
         pstr <= next_pstr;
         RESULT <= next_result;
         RESULT_WORD <= next_result_word;
         STATUS <= next_status;
         PC_OUT <= next_pc_out;
         RETURN_ADDR <= next_return_addr;
         WRITE_DEST <= next_write_dest;
         WRITE_WORD <= next_write_word;
         PUSH_RETURN <= next_push_return;
         DONE <= next_done;
         BUSY <= (next_state == st_busy);
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   logic go;
   assign go = START && (state == st_idle);

   chk_add_result: assert property (go && OPCODE == op_add |=>
      DONE && WRITE_DEST && RESULT == $past(DEST) + $past(SRC))
      else $error("add result wrong");
   chk_word_add: assert property (go &&
      OPCODE == op_word_add_immediate
      |=> BUSY && !DONE ##1 DONE && WRITE_WORD &&
      RESULT_WORD == $past(WORD_IN, 2) + {10'h000, $past(WORD_K, 2)})
      else $error("word add wrong");
   chk_sub_carry: assert property (go && OPCODE == op_subtract |=>
      STATUS[`MAB_FLAG_C] == ($past(SRC) > $past(DEST)))
      else $error("subtract borrow wrong");
   chk_borrow_sub: assert property (go &&
      OPCODE == op_subtract_with_borrow |=> RESULT == $past(DEST) -
      $past(SRC) - {7'h00, $past(STATUS[`MAB_FLAG_C])})
      else $error("borrow subtract wrong");
   chk_word_sub: assert property (go &&
      OPCODE == op_word_subtract_immediate |=> !DONE ##1 DONE &&
      STATUS[`MAB_FLAG_S] == (STATUS[`MAB_FLAG_N] ^ STATUS[`MAB_FLAG_V]))
      else $error("word subtract flags wrong");
   chk_logic_flags: assert property (go && OPCODE inside {op_and,
      op_or, op_exclusive_or, op_self_and_test, op_register_zero} |=>
      !STATUS[`MAB_FLAG_V] && STATUS[`MAB_FLAG_N] == RESULT[7] &&
      STATUS[`MAB_FLAG_Z] == (RESULT == 8'h00))
      else $error("logic flags wrong");
   chk_invert_val: assert property (go && OPCODE == op_bitwise_invert
      |=> RESULT == ~$past(DEST) && STATUS[`MAB_FLAG_C])
      else $error("invert wrong");
   chk_negate_val: assert property (go &&
      OPCODE == op_arithmetic_invert |=> RESULT == 8'h00 - $past(DEST))
      else $error("negate wrong");
   chk_mask_clear: assert property (go &&
      OPCODE == op_clear_bits_mask |=> RESULT == ($past(DEST) & ~$past(IMM)))
      else $error("clear mask wrong");
   chk_incdec_carry: assert property (go &&
      OPCODE inside {op_increment, op_minus_one} |=>
      STATUS[`MAB_FLAG_C] == $past(STATUS[`MAB_FLAG_C]))
      else $error("carry changed");
   chk_fill_flags: assert property (go &&
      OPCODE == op_register_fill_ones |=> RESULT == `MAB_ONES &&
      $stable(STATUS)) else $error("fill ones wrong");
   chk_jump_cycles: assert property (go && OPCODE == op_absolute_jump
      |=> BUSY ##1 BUSY ##1 DONE && PC_OUT == $past(TARGET, 3))
      else $error("jump timing wrong");
   chk_call_cycles: assert property (go && OPCODE == op_direct_call
      |=> !DONE [*3] ##1 DONE && PUSH_RETURN && STATUS == $past(STATUS, 4))
      else $error("call timing wrong");
   chk_skip_equal: assert property (go &&
      OPCODE == op_compare_skip_equal && DEST == SRC && !NEXT_TWO_WORD |=>
      !DONE ##1 DONE && PC_OUT == $past(PC_IN, 2) + `MAB_PC_SKIP1)
      else $error("skip equal wrong");
   chk_compare_hold: assert property (go && OPCODE inside
      {op_compare_only, op_compare_with_borrow, op_compare_immediate} |=>
      DONE && !WRITE_DEST) else $error("compare wrote");
   chk_bit_noskip: assert property (go &&
      OPCODE == op_skip_reg_bit_set && !SRC[BIT_SEL] |=>
      DONE && PC_OUT == $past(PC_IN) + `MAB_PC_STEP)
      else $error("bit skip wrong");
   chk_io_skip: assert property (go && OPCODE == op_skip_io_bit_set
      && IO_REG[BIT_SEL] && NEXT_TWO_WORD |=> !DONE [*2] ##1 DONE &&
      $stable(STATUS)) else $error("io skip wrong");
   chk_branch_taken: assert property (go &&
      OPCODE == op_branch_flag_set && STATUS[FLAG_SEL] |=> ##1 DONE &&
      PC_OUT == $past(PC_IN, 2) + $past(OFFSET, 2) + `MAB_PC_STEP)
      else $error("branch target wrong");
   chk_flag_keep: assert property (go && OPCODE == op_and |=>
      STATUS[`MAB_FLAG_H] == $past(STATUS[`MAB_FLAG_H]))
      else $error("untouched flag changed");

   cov_word_op: cover property (go && OPCODE == op_word_add_immediate);
   cov_call: cover property (go && OPCODE == op_direct_call ##4 DONE);
   cov_long_skip: cover property (go && skip && NEXT_TWO_WORD);
   cov_back2back: cover property (DONE && go);
endmodule
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "mab_consts.svh"
module tb;
   import mab_pkg::*;
   logic CLK = 1'b0, RST_B = 1'b0, START = 1'b0, NEXT_TWO_WORD = 1'b0;
   logic WRITE_DEST, WRITE_WORD, PUSH_RETURN, DONE, BUSY;
   mab_op_t OPCODE = op_add;
   logic [7:0] DEST = 8'h00, SRC = 8'h00, IMM = 8'h00, IO_REG = 8'h00;
   logic [7:0] RESULT, STATUS;
   logic [15:0] WORD_IN = 16'h0000, PC_IN = 16'h0100, OFFSET = 16'hfffe;
   logic [15:0] TARGET = 16'hbeef, Z_PTR = 16'h1234;
   logic [15:0] RESULT_WORD, PC_OUT, RETURN_ADDR;
   logic [5:0] WORD_K = 6'h00;
   logic [2:0] BIT_SEL = 3'h0, FLAG_SEL = 3'h0;
   logic [7:0] sx = 8'h00;
   int bad_count = 0, n_compared = 0, cycles = 0;
   mab_exec uut (.CLK(CLK), .RST_B(RST_B), .START(START), .OPCODE(OPCODE),
      .DEST(DEST), .SRC(SRC), .IMM(IMM), .WORD_IN(WORD_IN), .WORD_K(WORD_K),
      .PC_IN(PC_IN), .OFFSET(OFFSET), .TARGET(TARGET), .Z_PTR(Z_PTR),
      .NEXT_TWO_WORD(NEXT_TWO_WORD), .IO_REG(IO_REG), .BIT_SEL(BIT_SEL),
      .FLAG_SEL(FLAG_SEL), .RESULT(RESULT), .WRITE_DEST(WRITE_DEST),
      .RESULT_WORD(RESULT_WORD), .WRITE_WORD(WRITE_WORD), .STATUS(STATUS),
      .PC_OUT(PC_OUT), .RETURN_ADDR(RETURN_ADDR),
      .PUSH_RETURN(PUSH_RETURN), .DONE(DONE), .BUSY(BUSY));
   // 200 MHz core clock
   always #2.5 CLK = ~CLK;
   // hang guard: whole run needs under 150 cycles
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic finish_test;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
      end
   endtask
   // one instruction with a free cycle before it, so START is never
   // assigned twice in one time step; returns in the DONE cycle
   task automatic run(input mab_op_t op, input int cyc, input logic [7:0] r,
      input logic wd, input logic [7:0] mask, input logic [7:0] fl,
      input logic [15:0] pc);
      int n;
      logic b1;
      @(posedge CLK);
      #1 OPCODE = op;
      START = 1'b1;
      @(posedge CLK);
      #1 START = 1'b0;
      b1 = BUSY;
      n = 1;
      while (DONE !== 1'b1 && n < 8) begin
         @(posedge CLK);
         #1 n++;
      end
      sx = (sx & ~mask) | (fl & mask);
      check(16'(n), 16'(cyc));
      check({15'h0, b1}, {15'h0, cyc > 1});
      check({15'h0, WRITE_DEST}, {15'h0, wd});
      if (wd) check({8'h0, RESULT}, {8'h0, r});
      check({8'h0, STATUS}, {8'h0, sx});
      check(PC_OUT, pc);
   endtask
   // byte operation; immediate and source carry the same operand
   task automatic alu(input mab_op_t op, input logic [7:0] d, s, r,
      input logic wd, input logic [7:0] mask, fl);
      DEST = d;
      SRC = s;
      IMM = s;
      run(op, 1, r, wd, mask, fl, PC_IN + 16'h0001);
   endtask
   // flow change: no flag may move
   task automatic flow(input mab_op_t op, input int cyc,
      input logic [15:0] pc, ra, input logic push);
      run(op, cyc, 8'h00, 1'b0, `MAB_MASK_NONE, 8'h00, pc);
      check({15'h0, PUSH_RETURN}, {15'h0, push});
      if (push) check(RETURN_ADDR, ra);
   endtask
   task automatic t_arith;
      alu(op_add, 8'h0f, 8'h01, 8'h10, 1, `MAB_MASK_ARITH, 8'h20);
      alu(op_add, 8'h80, 8'h80, 8'h00, 1, `MAB_MASK_ARITH, 8'h0b);
      alu(op_add_carry, 8'h01, 8'h01, 8'h03, 1, `MAB_MASK_ARITH, 0);
      alu(op_subtract, 8'h10, 8'h01, 8'h0f, 1,
         `MAB_MASK_ARITH, 8'h20);
      alu(op_subtract_immediate, 0, 1, 8'hff, 1,
         `MAB_MASK_ARITH, 8'h25);
      alu(op_subtract_with_borrow, 5, 2, 2, 1, `MAB_MASK_ARITH, 0);
      alu(op_subtract_immediate, 0, 1, 8'hff, 1,
         `MAB_MASK_ARITH, 8'h25);
      alu(op_subtract_borrow_immediate, 8'h10, 0, 8'h0f, 1,
         `MAB_MASK_ARITH, 8'h20);
      $display("test arith done");
   endtask
   task automatic t_word;
      WORD_IN = 16'hffff;
      WORD_K = 6'h01;
      run(op_word_add_immediate, 2, 0, 0, `MAB_MASK_WORD, 8'h03,
         16'h0101);
      check(RESULT_WORD, 16'h0000);
      check({15'h0, WRITE_WORD}, 16'h0001);
      WORD_IN = 16'h7fc1;
      WORD_K = 6'h3f;
      run(op_word_add_immediate, 2, 0, 0, `MAB_MASK_WORD, 8'h0c,
         16'h0101);
      check(RESULT_WORD, 16'h8000);
      WORD_IN = 16'h0000;
      run(op_word_subtract_immediate, 2, 0, 0, `MAB_MASK_WORD, 8'h15,
         16'h0101);
      check(RESULT_WORD, 16'hffc1);
      check({15'h0, WRITE_WORD}, 16'h0001);
      $display("test word done");
   endtask
   task automatic t_logic;
      // overflow set first so that the logic ops must clear it
      alu(op_add, 8'h7f, 8'h01, 8'h80, 1, `MAB_MASK_ARITH, 8'h2c);
      alu(op_and, 8'hf0, 8'h80, 8'h80, 1,
         `MAB_MASK_LOGIC, 8'h04);
      alu(op_and_immediate, 8'h0f, 8'hf0, 0, 1, `MAB_MASK_LOGIC, 2);
      alu(op_or, 8'h01, 8'h02, 8'h03, 1, `MAB_MASK_LOGIC, 0);
      alu(op_or_immediate, 8'h80, 1, 8'h81, 1, `MAB_MASK_LOGIC, 4);
      alu(op_exclusive_or, 8'haa, 8'haa, 0, 1, `MAB_MASK_LOGIC, 2);
      $display("test logic done");
   endtask
   task automatic t_unary;
      alu(op_bitwise_invert, 0, 0, 8'hff, 1, `MAB_MASK_INV, 8'h05);
      alu(op_arithmetic_invert, 1, 1, 8'hff, 1,
         `MAB_MASK_ARITH, 8'h25);
      alu(op_arithmetic_invert, 8'h80, 8'h80, 8'h80, 1,
         `MAB_MASK_ARITH, 8'h0d);
      alu(op_set_bits_mask, 8'h10, 8'h81, 8'h91, 1,
         `MAB_MASK_LOGIC, 4);
      alu(op_clear_bits_mask, 8'hf3, 8'h30, 8'hc3, 1,
         `MAB_MASK_LOGIC, 4);
      alu(op_increment, 8'h7f, 8'h7f, 8'h80, 1,
         `MAB_MASK_LOGIC, 8'h0c);
      alu(op_minus_one, 8'h80, 8'h80, 8'h7f, 1,
         `MAB_MASK_LOGIC, 8'h08);
      alu(op_self_and_test, 8'h80, 8'h80, 8'h80, 1,
         `MAB_MASK_LOGIC, 4);
      alu(op_minus_one, 1, 1, 0, 1, `MAB_MASK_LOGIC, 2);
      alu(op_register_zero, 8'h5a, 8'h5a, 0, 1, `MAB_MASK_LOGIC, 2);
      alu(op_register_fill_ones, 8'h12, 8'h12, 8'hff, 1,
         `MAB_MASK_NONE, 0);
      $display("test unary done");
   endtask
   task automatic t_compare;
      alu(op_compare_only, 8'h10, 8'h01, 0, 0,
         `MAB_MASK_ARITH, 8'h20);
      alu(op_compare_immediate, 0, 1, 0, 0, `MAB_MASK_ARITH, 8'h25);
      alu(op_compare_with_borrow, 5, 2, 0, 0, `MAB_MASK_ARITH, 0);
      $display("test compare done");
   endtask
   task automatic t_flow;
      flow(op_relative_jump, 2, 16'h00ff, 0, 0);
      flow(op_indirect_jump, 2, 16'h1234, 0, 0);
      flow(op_absolute_jump, 3, 16'hbeef, 0, 0);
      flow(op_relative_call, 3, 16'h00ff, 16'h0101, 1);
      flow(op_indirect_call, 3, 16'h1234, 16'h0101, 1);
      flow(op_direct_call, 4, 16'hbeef, 16'h0102, 1);
      $display("test flow done");
   endtask
   task automatic t_skip;
      DEST = 8'h04;
      SRC = 8'h04;
      IO_REG = 8'hfb;
      BIT_SEL = 3'h2;
      flow(op_compare_skip_equal, 2, 16'h0102, 0, 0);
      NEXT_TWO_WORD = 1'b1;
      flow(op_compare_skip_equal, 3, 16'h0103, 0, 0);
      flow(op_skip_reg_bit_set, 3, 16'h0103, 0, 0);
      flow(op_skip_reg_bit_clear, 1, 16'h0101, 0, 0);
      // bit 3: set in the io value, clear in the source register
      BIT_SEL = 3'h3;
      flow(op_skip_io_bit_set, 3, 16'h0103, 0, 0);
      flow(op_skip_reg_bit_set, 1, 16'h0101, 0, 0);
      BIT_SEL = 3'h2;
      NEXT_TWO_WORD = 1'b0;
      flow(op_skip_io_bit_clear, 2, 16'h0102, 0, 0);
      flow(op_skip_io_bit_set, 1, 16'h0101, 0, 0);
      SRC = 8'h05;
      flow(op_compare_skip_equal, 1, 16'h0101, 0, 0);
      alu(op_compare_immediate, 0, 1, 0, 0, `MAB_MASK_ARITH, 8'h25);
      FLAG_SEL = 3'h0;
      flow(op_branch_flag_set, 2, 16'h00ff, 0, 0);
      FLAG_SEL = 3'h1;
      flow(op_branch_flag_set, 1, 16'h0101, 0, 0);
      $display("test skip done");
   endtask
   // request held during a long call must be ignored, then taken at DONE
   task automatic t_refuse;
      int n;
      @(posedge CLK);
      #1 OPCODE = op_direct_call;
      START = 1'b1;
      @(posedge CLK);
      #1 OPCODE = op_add;
      DEST = 8'h01;
      SRC = 8'h02;
      n = 1;
      while (DONE !== 1'b1 && n < 8) begin
         @(posedge CLK);
         #1 n++;
      end
      check(16'(n), 16'h0004);
      @(posedge CLK);
      #1 START = 1'b0;
      check({15'h0, DONE}, 16'h0001);
      check({8'h0, RESULT}, 16'h0003);
      sx = sx & ~8'(`MAB_MASK_ARITH);
      $display("test refuse done");
   endtask
   // mid-run reset must clear the flags and pulses
   task automatic t_reset;
      @(posedge CLK);
      #1 RST_B = 1'b0;
      @(posedge CLK);
      #1 check({8'h0, STATUS}, 16'h0000);
      check({14'h0, DONE, BUSY}, 16'h0000);
      check(PC_OUT, 16'h0000);
      RST_B = 1'b1;
      sx = 8'h00;
      alu(op_add, 8'h0f, 8'h01, 8'h10, 1, `MAB_MASK_ARITH, 8'h20);
      $display("test reset done");
   endtask
   initial begin
      repeat (2) @(posedge CLK);
      #1 RST_B = 1'b1;
      check({8'h0, STATUS}, 16'h0000);
      t_arith();
      t_word();
      t_logic();
      t_unary();
      t_compare();
      t_flow();
      t_skip();
      t_refuse();
      t_reset();
      finish_test();
   end
endmodule
`default_nettype wire
